// *** verilog/ucr_regs.svh ***
// Timing and layout constants of the UART receive clock and data recovery
`ifndef UCR_REGS_SVH
`define UCR_REGS_SVH

// ============================================================
// Oversampling
`define UCR_SPB_NORMAL      5'h10
`define UCR_SPB_DOUBLE      5'h08

// ============================================================
// Majority vote window, first sample number
`define UCR_VOTE_FIRST_NORMAL 5'h08
`define UCR_VOTE_FIRST_DOUBLE 5'h04
`define UCR_VOTE_SPAN         5'h02

// ============================================================
// Character length bounds and reset values
`define UCR_CHAR_MIN        4'h5
`define UCR_CHAR_MAX        4'h9
`define UCR_LINE_IDLE       1'b1
`define UCR_CNT_IDLE        5'h00

`endif

// *** verilog/ucr_pkg.sv ***
// Types shared by the UART receive recovery modules
`default_nettype none
package ucr_pkg;

  // Receiver frame phases
  typedef enum logic [2:0] {
    UCR_IDLE,
    UCR_START,
    UCR_DATA,
    UCR_PARITY,
    UCR_STOP
  } ucr_state_t;

  // Received character, up to nine bits, upper bits zero
  typedef logic [8:0] ucr_char_t;

  // Sample counter width, holds 0 to 16
  typedef logic [4:0] ucr_cnt_t;

endpackage
`default_nettype wire

// *** verilog/ucr_line_if.sv ***
// Sampled line and vote carried from the sampler to the recovery engine
`timescale 1ns/1ps
`default_nettype none
interface ucr_line_if;
  logic line;      // Synchronised level, current sample
  logic prev;      // Level of the previous sample tick
  logic vote;      // Majority of the last three samples incl. current

  modport sampler  (output line, prev, vote);
  modport recovery (input  line, prev, vote);
endinterface
`default_nettype wire

// *** verilog/ucr_sampler.sv ***
// Input synchroniser, sample history and three-sample majority voter
`timescale 1ns/1ps
`default_nettype none
`include "ucr_regs.svh"
module ucr_sampler (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        rxd_i,
  input  wire logic        sample_tick_i,
  ucr_line_if.sampler      line_o
);

  logic       sync1_q;
  logic       sync2_q;
  logic [1:0] hist_q;

  // ============================================================
  // Synchroniser: first stage is read only by the second
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync1_q <= `UCR_LINE_IDLE;
      sync2_q <= `UCR_LINE_IDLE;
    end else begin
      sync1_q <= rxd_i;
      sync2_q <= sync1_q;
    end
  end

  // ============================================================
  // Sample history, shifted once per sample tick
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hist_q <= {2{`UCR_LINE_IDLE}};
    end else if (sample_tick_i) begin
      hist_q <= {hist_q[0], sync2_q};
    end
  end

  // Majority of two older samples and the one taken now
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  assign line_o.line = sync2_q;
  assign line_o.prev = hist_q[0];
  assign line_o.vote = majority(hist_q[1], hist_q[0], sync2_q);

endmodule
`default_nettype wire

// *** verilog/ucr_rx_recovery.sv ***
// UART receive clock recovery and data recovery engine
// ============================================================
`timescale 1ns/1ps
`default_nettype none
`include "ucr_regs.svh"
module ucr_rx_recovery (
  input  wire logic          ref_clk_i,
  input  wire logic          reset_i,
  input  wire logic          rxd_i,
  input  wire logic          sample_tick_i,
  input  wire logic          rx_enable_i,
  input  wire logic          double_speed_select_i,
  input  wire logic          parity_check_enable_i,
  input  wire logic          parity_odd_i,
  input  wire logic [3:0]    char_bits_i,
  output ucr_pkg::ucr_char_t rx_data_o,
  output logic               parity_error_o,
  output logic               framing_error_flag_o,
  output logic               rx_valid_o,
  output logic               rx_busy_o
);
  import ucr_pkg::*;

  // ============================================================
  // Decode helpers
  // Samples per bit for the selected speed
  function automatic ucr_cnt_t spb_f(input logic dbl);
    spb_f = dbl ? `UCR_SPB_DOUBLE : `UCR_SPB_NORMAL;
  endfunction

  // Number of the last voting sample, the point where the vote is final
  function automatic ucr_cnt_t vote_last_f(input logic dbl);
    ucr_cnt_t first;
    first = dbl ? `UCR_VOTE_FIRST_DOUBLE : `UCR_VOTE_FIRST_NORMAL;
    vote_last_f = ucr_cnt_t'(first + `UCR_VOTE_SPAN);
  endfunction

  // Character length clamped into the supported five to nine bits
  function automatic logic [3:0] char_len_f(input logic [3:0] bits);
    if (bits < `UCR_CHAR_MIN) begin
      char_len_f = `UCR_CHAR_MIN;
    end else if (bits > `UCR_CHAR_MAX) begin
      char_len_f = `UCR_CHAR_MAX;
    end else begin
      char_len_f = bits;
    end
  endfunction

  // ============================================================
  // Sampler instance
  ucr_line_if line_if ();

  ucr_sampler u_sampler (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .rxd_i         (rxd_i),
    .sample_tick_i (sample_tick_i),
    .line_o        (line_if.sampler)
  );

  // ============================================================
  // State
  ucr_state_t state_q;
  ucr_cnt_t   cnt_q;
  logic [3:0] bit_idx_q;
  ucr_char_t  data_q;
  logic       par_q;

  ucr_cnt_t   spb;
  ucr_cnt_t   vote_last;
  ucr_cnt_t   cnt_nxt;
  logic [3:0] char_len;
  logic       bit_end;
  logic       vote_now;
  logic       fall_edge;
  logic       frame_done;

  // ============================================================
  // Per-tick timing decode
  always_comb begin
    spb       = spb_f(double_speed_select_i);
    vote_last = vote_last_f(double_speed_select_i);
    char_len  = char_len_f(char_bits_i);
    // Sample number of the tick now arriving; wraps 16->1 or 8->1
    bit_end   = (cnt_q == spb);
    cnt_nxt   = bit_end ? 5'h01 : ucr_cnt_t'(cnt_q + 5'h01);
    vote_now  = sample_tick_i && (cnt_nxt == vote_last);
    // Edge needs a high sample before the low one, so a held break
    // does not retrigger frames back to back
    fall_edge = sample_tick_i && line_if.prev && !line_if.line;
    frame_done = (state_q == UCR_STOP) && vote_now;
  end

  // ============================================================
  // Frame phase and sample counter
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !rx_enable_i) begin
      // Disabling drops a frame in flight at once
      state_q <= UCR_IDLE;
      cnt_q   <= `UCR_CNT_IDLE;
    end else begin
      case (state_q)
        UCR_IDLE: begin
          cnt_q <= `UCR_CNT_IDLE;
          if (fall_edge) begin
            state_q <= UCR_START;
            cnt_q   <= 5'h01;
          end
        end
        UCR_START: begin
          if (sample_tick_i) begin
            cnt_q <= cnt_nxt;
            if (vote_now && line_if.vote) begin
              state_q <= UCR_IDLE;
              cnt_q   <= `UCR_CNT_IDLE;
            end else if (bit_end) begin
              state_q <= UCR_DATA;
            end
          end
        end
        UCR_DATA: begin
          if (sample_tick_i) begin
            cnt_q <= cnt_nxt;
            if (bit_end && (bit_idx_q == char_len - 4'h1)) begin
              state_q <= parity_check_enable_i ? UCR_PARITY : UCR_STOP;
            end
          end
        end
        UCR_PARITY: begin
          if (sample_tick_i) begin
            cnt_q <= cnt_nxt;
            if (bit_end) begin
              state_q <= UCR_STOP;
            end
          end
        end
        UCR_STOP: begin
          if (sample_tick_i) begin
            cnt_q <= cnt_nxt;
            // Leave at the last voting sample; later stop bits are idle
            if (vote_now) begin
              state_q <= UCR_IDLE;
              cnt_q   <= `UCR_CNT_IDLE;
            end
          end
        end
        default: begin
          state_q <= UCR_IDLE;
          cnt_q   <= `UCR_CNT_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Data bit index and character assembly, LSB first
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bit_idx_q <= 4'h0;
      data_q    <= '0;
    end else if (state_q == UCR_IDLE) begin
      // Cleared per frame so unused upper bits read as zero
      bit_idx_q <= 4'h0;
      data_q    <= '0;
    end else if (state_q == UCR_DATA && sample_tick_i) begin
      if (vote_now) begin
        data_q[bit_idx_q] <= line_if.vote;
      end
      if (bit_end) begin
        bit_idx_q <= bit_idx_q + 4'h1;
      end
    end
  end

  // ============================================================
  // Parity bit capture
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      par_q <= 1'b0;
    end else if (state_q == UCR_PARITY && vote_now) begin
      par_q <= line_if.vote;
    end
  end

  // ============================================================
  // Frame hand-off toward the receive buffer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_valid_o           <= 1'b0;
      rx_data_o            <= '0;
      parity_error_o       <= 1'b0;
      framing_error_flag_o <= 1'b0;
    end else begin
      rx_valid_o <= rx_enable_i && frame_done;
      if (rx_enable_i && frame_done) begin
        rx_data_o            <= data_q;
        // Stop bit resolved low marks the frame, stored with it
        framing_error_flag_o <= !line_if.vote;
        // Even parity, or odd with parity_odd_i set: xor of data, parity bit and parity_odd_i is zero when good
        parity_error_o       <= parity_check_enable_i &&
                                ((^data_q) ^ par_q ^ parity_odd_i);
      end
    end
  end

  // Busy while a frame is being received
  assign rx_busy_o = (state_q != UCR_IDLE);

endmodule
`default_nettype wire

// *** bench/ucr_rx_recovery_monitor.sv ***
// Port checker for the UART receive recovery engine
`timescale 1ns/1ps
`default_nettype none
module ucr_rx_monitor (
  input wire logic               ref_clk_i,
  input wire logic               reset_i,
  input wire logic               rxd_i,
  input wire logic               sample_tick_i,
  input wire logic               rx_enable_i,
  input wire logic               parity_check_enable_i,
  input wire logic [3:0]         char_bits_i,
  input wire ucr_pkg::ucr_char_t rx_data_o,
  input wire logic               parity_error_o,
  input wire logic               framing_error_flag_o,
  input wire logic               rx_valid_o,
  input wire logic               rx_busy_o
);
  // ============================================================
  // Checks, all in the one clock domain
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  AST_VALID_ONE_CYCLE: assert property (rx_valid_o |=> !rx_valid_o) else $error("valid longer than one cycle");
  AST_VALID_AFTER_TICK: assert property (rx_valid_o |-> $past(sample_tick_i))
    else $error("valid not after tick");
  AST_VALID_FROM_BUSY: assert property (rx_valid_o |-> $past(rx_busy_o) && !rx_busy_o)
    else $error("valid w/o frame");
  AST_OFF_IDLE: assert property (!rx_enable_i |=> !rx_busy_o && !rx_valid_o) else $error("busy while disabled");
  AST_START_ON_TICK: assert property ($rose(rx_busy_o) |-> $past(sample_tick_i)) else $error("start off tick");
  // Line passes two flops and the state flop, so the low sample is three clocks old
  AST_START_LOW: assert property ($rose(rx_busy_o) |-> !$past(rxd_i, 3) || !$past(rxd_i, 4))
    else $error("start without low line");
  AST_DATA_HOLD: assert property (!rx_valid_o |-> $stable(rx_data_o)) else $error("data moved between frames");
  // Error flags belong to their frame, so they only move with the strobe
  AST_FLAGS_HOLD: assert property (!rx_valid_o |-> $stable(framing_error_flag_o) && $stable(parity_error_o))
    else $error("error flags moved between frames");
  AST_PE_OFF: assert property (rx_valid_o && !parity_check_enable_i |-> !parity_error_o)
    else $error("parity error while unchecked");
  AST_SHORT_CHAR: assert property (rx_valid_o && char_bits_i == 4'h5 |-> rx_data_o[8:5] == 4'h0)
    else $error("upper bits not zero");
endmodule
bind ucr_rx_recovery ucr_rx_monitor MON (.ref_clk_i, .reset_i, .rxd_i, .sample_tick_i, .rx_enable_i,
  .parity_check_enable_i, .char_bits_i, .rx_data_o, .parity_error_o, .framing_error_flag_o, .rx_valid_o, .rx_busy_o);
`default_nettype wire

// *** bench/ucr_tx_model.sv ***
// Remote asynchronous transmitter model driving the serial line
`timescale 1ns/1ps
`default_nettype none
module ucr_tx_model (
  input  wire logic ref_clk_i,
  output var  logic rxd_o
);
  // ============================================================
  // Line driver, idle high from time zero
  initial rxd_o = 1'b1;
  // Exact rate, 4 clocks per sample, so no baud error at all
  task automatic hold(input logic v, input int n);
    rxd_o <= v;
    repeat (n * 4) @(posedge ref_clk_i);
  endtask
  // Start, data LSB first, optional parity, one stop of chosen length
  task automatic send(input logic [8:0] d, input int nb, spb, input logic pen, pb, sv, input int stop_n);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) hold(d[i], spb);
    if (pen) hold(pb, spb);
    hold(sv, stop_n);
  endtask
endmodule
`default_nettype wire

// *** bench/uart_rx_clock_data_recovery_tb.sv ***
// Self-checking bench of the UART receive recovery engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module uart_rx_clock_data_recovery_tb;
  import ucr_pkg::*;
  logic      ref_clk_i = 1'b0;
  logic      reset_i = 1'b1;
  logic      tick = 1'b0;
  logic      en = 1'b1;
  logic      dss = 1'b0;
  logic      pce = 1'b0;
  logic      podd = 1'b0;
  logic [3:0] cbits = 4'h8;
  logic      rxd, pe, fe, vld, busy, cap_fe, cap_pe;
  ucr_char_t data, cap_d;
  int        errors, checks_done, nvld, tcnt;
  // ============================================================
  // Clock, sample tick every 4 clocks, capture of each frame
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    tcnt <= tcnt + 1;
    tick <= (tcnt % 4 == 3);
    if (vld === 1'b1) begin
      nvld <= nvld + 1;
      cap_d <= data;
      cap_fe <= fe;
      cap_pe <= pe;
    end
  end
  ucr_tx_model TX (.ref_clk_i(ref_clk_i), .rxd_o(rxd));
  ucr_rx_recovery DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .rxd_i(rxd), .sample_tick_i(tick),
    .rx_enable_i(en), .double_speed_select_i(dss), .parity_check_enable_i(pce), .parity_odd_i(podd),
    .char_bits_i(cbits), .rx_data_o(data), .parity_error_o(pe), .framing_error_flag_o(fe),
    .rx_valid_o(vld), .rx_busy_o(busy));
  // ============================================================
  // Shared frame task and scenarios
  task automatic cfg(input logic s, p, o, input logic [3:0] c);
    @(posedge ref_clk_i);
    dss <= s;
    pce <= p;
    podd <= o;
    cbits <= c;
    @(posedge ref_clk_i);
  endtask
  task automatic frame(input ucr_char_t d, input int nb, spb, input logic pb, sv, perr);
    int n0;
    n0 = nvld;
    TX.send(d, nb, spb, pce, pb, sv, spb);
    TX.hold(1'b1, spb);
    `CHK("valid count", n0 + 1, nvld)
    `CHK("data", d, cap_d)
    `CHK("framing", ~sv, cap_fe)
    `CHK("parity", perr, cap_pe)
  endtask
  task automatic t_normal;
    cfg(1'b0, 1'b0, 1'b0, 4'h8);
    frame(9'h0A5, 8, 16, 1'b0, 1'b1, 1'b0);
    frame(9'h05A, 8, 16, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_double_parity;
    for (int o = 0; o < 2; o++) begin
      cfg(1'b1, 1'b1, o[0], 4'h9);
      frame(9'h1C3, 9, 8, ^9'h1C3 ^ o[0], 1'b1, 1'b0);
      frame(9'h1C3, 9, 8, ~(^9'h1C3 ^ o[0]), 1'b1, 1'b1);
    end
  endtask
  task automatic t_stop_error;
    cfg(1'b0, 1'b0, 1'b0, 4'h8);
    frame(9'h03C, 8, 16, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_noise;
    int n0;
    n0 = nvld;
    TX.hold(1'b0, 7);
    TX.hold(1'b1, 32);
    `CHK("rejected start", n0, nvld)
    `CHK("busy after reject", 1'b0, busy)
  endtask
  // Disabling mid-frame must drop the frame without a strobe
  task automatic t_disable;
    int n0;
    n0 = nvld;
    TX.hold(1'b0, 16);
    `CHK("busy in frame", 1'b1, busy)
    en <= 1'b0;
    TX.hold(1'b1, 16);
    `CHK("busy when disabled", 1'b0, busy)
    `CHK("frame dropped", n0, nvld)
    en <= 1'b1;
    @(posedge ref_clk_i);
  endtask
  task automatic t_back_to_back;
    int n0;
    cfg(1'b0, 1'b0, 1'b0, 4'h5);
    n0 = nvld;
    TX.send(9'h015, 5, 16, 1'b0, 1'b0, 1'b1, 12);
    TX.send(9'h00A, 5, 16, 1'b0, 1'b0, 1'b1, 16);
    TX.hold(1'b1, 16);
    `CHK("early start count", n0 + 2, nvld)
    `CHK("second data", 9'h00A, cap_d)
  endtask
  task automatic end_sim;
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_normal();
    t_double_parity();
    t_stop_error();
    t_noise();
    t_disable();
    t_back_to_back();
    end_sim();
  end
endmodule
`default_nettype wire
